//--- rtl/oag_params.svh
`ifndef OAG_PARAMS_SVH
`define OAG_PARAMS_SVH
// ==========================================================
// Register map, byte addresses on the AHB-Lite word bus
`define OAG_PTR_FILE_END 10'h100  // Pointer file spans 0x000..0x0FC
`define OAG_PAGE0_OFF    10'h100  // Page register, generator 0
`define OAG_PAGE1_OFF    10'h104  // Page register, generator 1
`define OAG_CTRL_OFF     10'h108  // Bank select
`define OAG_ADDR0_OFF    10'h10C  // Last address of generator 0
`define OAG_ADDR1_OFF    10'h110  // Last address of generator 1
// ==========================================================
// Field positions inside the pointer file address and the bank select register
`define OAG_GEN_BIT      7
`define OAG_BANK_BIT     6
`define OAG_KIND_HI      5
`define OAG_KIND_LO      4
`define OAG_NUM_HI       3
`define OAG_NUM_LO       2
`define OAG_CTRL_BANK    0
// ==========================================================
// Register kinds and reset values
`define OAG_KIND_IDX     2'h0
`define OAG_KIND_MOD     2'h1
`define OAG_KIND_LEN     2'h2
`define OAG_KIND_BASE    2'h3
`define OAG_REG_RST      16'h0000
`define OAG_PAGE_RST     8'h00
`endif

//--- rtl/oag_pkg.sv
package oag_pkg;
  // ========================================================
  // Widths
  localparam int PTR_W  = 16;
  localparam int PAGE_W = 8;
  localparam int ADDR_W = PTR_W + PAGE_W;

  typedef logic [PTR_W-1:0]  ptr_t;
  typedef logic [PAGE_W-1:0] page_t;
  typedef logic [ADDR_W-1:0] addr_t;

  // ========================================================
  // One operand access request from instruction decode
  typedef struct packed {
    logic       valid;    // Use a pointer this cycle
    logic [1:0] ptr_sel;  // Which of four pointers
    logic [1:0] mod_sel;  // Which of four modify registers
    logic       use_imm;  // Take the immediate instead
    logic [7:0] imm;      // Twos-complement immediate modify
    logic       pre;      // 1 pre-modify, 0 post-modify
  } opreq_s;

  // ========================================================
  // Whole state of the generator pair: [gen][bank][num]
  typedef struct packed {
    logic [1:0][1:0][3:0][PTR_W-1:0] idx;
    logic [1:0][1:0][3:0][PTR_W-1:0] mdf;
    logic [1:0][1:0][3:0][PTR_W-1:0] len;
    logic [1:0][1:0][3:0][PTR_W-1:0] base;
    logic [1:0][PAGE_W-1:0]          page;
    logic                            bank;
    logic [1:0][ADDR_W-1:0]          addr;
    logic [1:0]                      addr_vld;
    logic                            wr_pend;
    logic [9:0]                      wr_addr;
    logic [31:0]                     hrdata;
    logic                            hreadyout;
  } oag_state_s;
endpackage

//--- rtl/operand_address_generator.sv
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "oag_params.svh"
// Function
// RL1 - Two generators supply two operands per cycle
// RL2 - Four self-updating 16-bit pointers per generator
// RL3 - Pointer modified by one of four modify registers
// RL4 - Pre-modify no writeback; post-modify writes back
// RL5 - Immediate 8-bit twos-complement modify, both forms
// RL6 - Length and base make updates circular
// RL7 - Updates never carry into page bits
// RL8 - Secondary register bank switched at once
// RL9 - Output address is 24 bits wide
// RL10 - Page register supplies upper eight address bits
// RL11 - Circular overflow wraps by one length
module operand_address_generator #(
  parameter int NUM_GEN = 2
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire oag_pkg::opreq_s [1:0]  core_req,
  output logic [1:0][23:0]            op_addr,
  output logic [1:0]                  op_addr_vld,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp
);
  import oag_pkg::*;

  // ========================================================
  // Elaboration check
  if (NUM_GEN != 2) begin : g_chk
    $error("operand_address_generator serves exactly two generators");
  end

  oag_state_s s_r;
  oag_state_s s_nxt;
  ptr_t [1:0] cur_ptr;
  ptr_t [1:0] eff_mod;
  logic       bus_go;
  logic [2:0] unused_sz;

  // Modulo-aware pointer update inside one 64K page
  function automatic ptr_t upd(input ptr_t p, input ptr_t m, input ptr_t b,
                               input ptr_t l);
    logic [16:0] off;
    begin
      off = 17'h00000;
      if (l == `OAG_REG_RST) begin
        upd = p + m;                                      // RL7
      end else begin
        off = {1'b0, p - b} + {m[15], m};                 // RL6
        if (off[16]) begin
          off = off + {1'b0, l};                          // RL11
        end else if (off[15:0] >= l) begin
          off = off - {1'b0, l};                          // RL11
        end
        upd = b + off[15:0];                              // RL7
      end
    end
  endfunction

  // Selected pointer and effective modify value
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      cur_ptr[g] = s_r.idx[g][s_r.bank][core_req[g].ptr_sel];
      if (core_req[g].use_imm) begin
        eff_mod[g] = {{8{core_req[g].imm[7]}}, core_req[g].imm};  // RL5
      end else begin
        eff_mod[g] = s_r.mdf[g][s_r.bank][core_req[g].mod_sel];   // RL3
      end
    end
  end

  assign bus_go    = hsel & htrans[1] & hready;
  assign unused_sz = hsize;

  // ========================================================
  // Next state: core updates, then bus write, then read data
  always_comb begin
    logic [9:0] a;
    logic [1:0] bk;
    ptr_t       nv;
    a     = 10'h000;
    bk    = 2'h0;
    nv    = `OAG_REG_RST;
    s_nxt = s_r;
    s_nxt.hreadyout = 1'b1;
    // Two independent generators, one address each per cycle
    for (int g = 0; g < 2; g++) begin
      s_nxt.addr_vld[g] = core_req[g].valid;              // RL1
      if (core_req[g].valid) begin
        nv = upd(cur_ptr[g], eff_mod[g], s_r.base[g][s_r.bank][core_req[g].ptr_sel],
                 s_r.len[g][s_r.bank][core_req[g].ptr_sel]);
        if (core_req[g].pre) begin
          s_nxt.addr[g] = {s_r.page[g], nv};              // RL4 RL9 RL10
        end else begin
          s_nxt.addr[g] = {s_r.page[g], cur_ptr[g]};      // RL4 RL9 RL10
          s_nxt.idx[g][s_r.bank][core_req[g].ptr_sel] = nv;  // RL2
        end
      end
    end
    // Data phase of a bus write; it wins over a core update
    if (s_r.wr_pend) begin
      a = s_r.wr_addr;
      if (a < `OAG_PTR_FILE_END) begin
        bk = a[`OAG_KIND_HI:`OAG_KIND_LO];
        unique case (bk)
          `OAG_KIND_IDX: s_nxt.idx[a[`OAG_GEN_BIT]][a[`OAG_BANK_BIT]]
                           [a[`OAG_NUM_HI:`OAG_NUM_LO]] = hwdata[15:0];
          `OAG_KIND_MOD: s_nxt.mdf[a[`OAG_GEN_BIT]][a[`OAG_BANK_BIT]]
                           [a[`OAG_NUM_HI:`OAG_NUM_LO]] = hwdata[15:0];
          `OAG_KIND_LEN: s_nxt.len[a[`OAG_GEN_BIT]][a[`OAG_BANK_BIT]]
                           [a[`OAG_NUM_HI:`OAG_NUM_LO]] = hwdata[15:0];
          `OAG_KIND_BASE: s_nxt.base[a[`OAG_GEN_BIT]][a[`OAG_BANK_BIT]]
                           [a[`OAG_NUM_HI:`OAG_NUM_LO]] = hwdata[15:0];
        endcase
      end else if (a == `OAG_PAGE0_OFF) begin
        s_nxt.page[0] = hwdata[7:0];                      // RL10
      end else if (a == `OAG_PAGE1_OFF) begin
        s_nxt.page[1] = hwdata[7:0];                      // RL10
      end else if (a == `OAG_CTRL_OFF) begin
        s_nxt.bank = hwdata[`OAG_CTRL_BANK];              // RL8
      end
    end
    // Address phase: latch writes, answer reads from fresh state
    s_nxt.wr_pend = bus_go & hwrite;
    s_nxt.wr_addr = haddr[9:0] & 10'h3FC;
    s_nxt.hrdata  = 32'h00000000;
    if (bus_go && !hwrite && haddr[31:10] == 22'h000000) begin
      a = haddr[9:0] & 10'h3FC;
      if (a < `OAG_PTR_FILE_END) begin
        bk = a[`OAG_KIND_HI:`OAG_KIND_LO];
        unique case (bk)
          `OAG_KIND_IDX: s_nxt.hrdata[15:0] = s_nxt.idx[a[`OAG_GEN_BIT]]
                           [a[`OAG_BANK_BIT]][a[`OAG_NUM_HI:`OAG_NUM_LO]];
          `OAG_KIND_MOD: s_nxt.hrdata[15:0] = s_nxt.mdf[a[`OAG_GEN_BIT]]
                           [a[`OAG_BANK_BIT]][a[`OAG_NUM_HI:`OAG_NUM_LO]];
          `OAG_KIND_LEN: s_nxt.hrdata[15:0] = s_nxt.len[a[`OAG_GEN_BIT]]
                           [a[`OAG_BANK_BIT]][a[`OAG_NUM_HI:`OAG_NUM_LO]];
          `OAG_KIND_BASE: s_nxt.hrdata[15:0] = s_nxt.base[a[`OAG_GEN_BIT]]
                           [a[`OAG_BANK_BIT]][a[`OAG_NUM_HI:`OAG_NUM_LO]];
        endcase
      end else if (a == `OAG_PAGE0_OFF) begin
        s_nxt.hrdata[7:0] = s_nxt.page[0];
      end else if (a == `OAG_PAGE1_OFF) begin
        s_nxt.hrdata[7:0] = s_nxt.page[1];
      end else if (a == `OAG_CTRL_OFF) begin
        s_nxt.hrdata[0] = s_nxt.bank;
      end else if (a == `OAG_ADDR0_OFF) begin
        s_nxt.hrdata[23:0] = s_nxt.addr[0];
      end else if (a == `OAG_ADDR1_OFF) begin
        s_nxt.hrdata[23:0] = s_nxt.addr[1];
      end
    end
    if (haddr[31:10] != 22'h000000) begin
      s_nxt.wr_pend = 1'b0;                               // Unmapped writes dropped
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register, except hresp, which is tied low
  assign op_addr     = s_r.addr;
  assign op_addr_vld = s_r.addr_vld;
  assign hrdata      = s_r.hrdata;
  assign hreadyout   = s_r.hreadyout;
  assign hresp       = 1'b0;

  // ========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  ptr_t lin_sum0;
  ptr_t in_off0;
  assign lin_sum0 = cur_ptr[0] + eff_mod[0];
  // Offset of generator 0 pointer 2 inside its circular buffer
  assign in_off0  = s_r.idx[0][s_r.bank][2] - s_r.base[0][s_r.bank][2];

  property p_both_gen;
    core_req[0].valid && core_req[1].valid |=> op_addr_vld == 2'h3;
  endproperty
  a_both_gen: assert property (p_both_gen) else $error("Dual address missing"); // RL1

  property p_post_addr;
    core_req[0].valid && !core_req[0].pre |=> op_addr[0][15:0] == $past(cur_ptr[0]);
  endproperty
  a_post_addr: assert property (p_post_addr) else $error("Post address wrong"); // RL4

  property p_pre_keep;
    core_req[1].valid && core_req[1].pre && !s_r.wr_pend
      |=> s_r.idx[1] == $past(s_r.idx[1]);
  endproperty
  a_pre_keep: assert property (p_pre_keep) else $error("Pre-modify wrote back"); // RL4

  property p_mod_reg;
    core_req[0].valid && core_req[0].pre && !core_req[0].use_imm
      && s_r.len[0][s_r.bank][core_req[0].ptr_sel] == 16'h0000
      |=> op_addr[0][15:0] == $past(lin_sum0);
  endproperty
  a_mod_reg: assert property (p_mod_reg) else $error("Modify register sum wrong"); // RL3

  property p_imm_post;
    core_req[0].valid && !core_req[0].pre && core_req[0].use_imm && !s_r.wr_pend
      && s_r.len[0][s_r.bank][core_req[0].ptr_sel] == 16'h0000
      |=> s_r.idx[0][$past(s_r.bank)][$past(core_req[0].ptr_sel)] == $past(lin_sum0);
  endproperty
  a_imm_post: assert property (p_imm_post) else $error("Immediate update wrong"); // RL5

  property p_circ;
    core_req[0].valid && !core_req[0].pre && core_req[0].ptr_sel == 2'h2
      && !s_r.wr_pend && s_r.len[0][s_r.bank][2] != 16'h0000
      && in_off0 < s_r.len[0][s_r.bank][2]
      |=> in_off0 < s_r.len[0][s_r.bank][2];
  endproperty
  a_circ: assert property (p_circ) else $error("Pointer left circular buffer"); // RL11

  property p_page;
    core_req[1].valid |=> op_addr[1][23:16] == $past(s_r.page[1]);
  endproperty
  a_page: assert property (p_page) else $error("Page bits wrong"); // RL10

  property p_no_carry;
    core_req[0].valid && core_req[0].pre |=> op_addr[0][23:16] == $past(s_r.page[0]);
  endproperty
  a_no_carry: assert property (p_no_carry) else $error("Update reached page"); // RL7

  property p_shadow;
    core_req[0].valid && !s_r.wr_pend
      |=> s_r.idx[0][!$past(s_r.bank)] == $past(s_r.idx[0][!s_r.bank]);
  endproperty
  a_shadow: assert property (p_shadow) else $error("Inactive bank touched"); // RL8

  c_circ_wrap: cover property (core_req[0].valid
                               && s_r.len[0][s_r.bank][core_req[0].ptr_sel] != 16'h0000);
  c_bank_swap: cover property (!s_r.bank ##1 s_r.bank);
  c_dual:      cover property (core_req[0].valid && core_req[1].valid && core_req[0].pre);
endmodule // operand_address_generator

//--- tb/operand_bus_model.sv
`timescale 1ns/100ps
// ==========================================================
// Memory address bus side: counts dual operand fetches
module operand_bus_model (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [1:0][23:0] op_addr,
  input  wire logic [1:0]       op_addr_vld,
  output logic      [7:0]       dual_cnt,
  output logic      [23:0]      last_dm
);
  // Both buses fetch in one cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dual_cnt <= 8'h00;
      last_dm  <= 24'h000000;
    end else begin
      if (op_addr_vld == 2'h3) begin
        dual_cnt <= dual_cnt + 8'h01;
      end
      if (op_addr_vld[1]) begin
        last_dm <= op_addr[1];
      end
    end
  end
endmodule // operand_bus_model

//--- tb/dual_data_address_generator_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, a, b); end end
module dual_data_address_generator_tb;
  import oag_pkg::*;
  logic                  clk_sys = 1'b0;
  logic                  rst     = 1'b1;
  opreq_s [1:0]          core_req = '0;
  logic   [1:0][23:0]    op_addr;
  logic   [1:0]          op_addr_vld;
  logic                  hsel = 1'b0;
  logic   [31:0]         haddr = 32'h0;
  logic   [1:0]          htrans = 2'h0;
  logic                  hwrite = 1'b0;
  logic   [31:0]         hwdata = 32'h0;
  logic   [31:0]         hrdata;
  logic                  hreadyout;
  logic                  hresp;
  logic   [7:0]          dual_cnt;
  logic   [23:0]         last_dm;
  logic   [31:0]         q;
  int                    err_total = 0;
  int                    comparisons = 0;
  // ========================================================
  // Clock, design and bus partner
  always #20 clk_sys = ~clk_sys;
  operand_address_generator i_dut (
    .clk_sys(clk_sys), .rst(rst), .core_req(core_req), .op_addr(op_addr),
    .op_addr_vld(op_addr_vld), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  operand_bus_model i_bus (
    .clk_sys(clk_sys), .rst(rst), .op_addr(op_addr), .op_addr_vld(op_addr_vld),
    .dual_cnt(dual_cnt), .last_dm(last_dm));
  // ========================================================
  // Pointer file address from generator, bank, kind, number
  function automatic logic [31:0] ra(input logic g, input logic b,
                                     input logic [1:0] k, input logic [1:0] n);
    return {24'h000000, g, b, k, n, 2'h0};
  endfunction
  // Single AHB-Lite transfer, waits on hready in both phases
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    // Address phase stands until hready is seen high; watchdog ends a hang
    do begin
      @(posedge clk_sys);
    end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    // Data phase stands until hready is seen high again
    do begin
      @(posedge clk_sys);
    end while (hreadyout !== 1'b1);
    q = hrdata;
    hsel <= 1'b0;
  endtask
  // One core request on one generator, then settle
  task automatic req(input int g, input logic [1:0] p, input logic [1:0] m,
                     input logic ui, input logic [7:0] im, input logic pr);
    @(posedge clk_sys);
    core_req[g] <= '{valid:1'b1, ptr_sel:p, mod_sel:m, use_imm:ui, imm:im, pre:pr};
    @(posedge clk_sys);
    core_req[g].valid <= 1'b0;
    #1;
    `CHK(op_addr_vld[g], 1'b1)
  endtask
  // Verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard
  initial begin
    #(40 * 5000);
    err_total++;
    conclude();
  end
  // ========================================================
  // Test sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, ra(0, 0, 0, 0), 32'h0); `CHK(q, 32'h0)
    bus(1'b0, 32'h100, 32'h0);        `CHK(q, 32'h0)
    bus(1'b1, 32'h100, 32'h12);
    bus(1'b1, 32'h104, 32'h34);
    // Post-modify by modify register
    bus(1'b1, ra(0, 0, 0, 0), 32'h10);
    bus(1'b1, ra(0, 0, 1, 1), 32'h3);
    req(0, 2'h0, 2'h1, 1'b0, 8'h00, 1'b0); `CHK(op_addr[0], 24'h120010)
    bus(1'b0, ra(0, 0, 0, 0), 32'h0);      `CHK(q, 32'h13)
    // Pre-modify by modify register leaves the pointer alone
    req(0, 2'h0, 2'h1, 1'b0, 8'h00, 1'b1); `CHK(op_addr[0], 24'h120016)
    bus(1'b0, ra(0, 0, 0, 0), 32'h0);      `CHK(q, 32'h13)
    $display("test post_modify done");
    // Pre-modify by negative immediate
    bus(1'b1, ra(1, 0, 0, 1), 32'h100);
    req(1, 2'h1, 2'h0, 1'b1, 8'hFE, 1'b1); `CHK(op_addr[1], 24'h3400FE)
    bus(1'b0, ra(1, 0, 0, 1), 32'h0);      `CHK(q, 32'h100)
    $display("test pre_modify done");
    // Circular buffer wraps both ways
    bus(1'b1, ra(0, 0, 3, 2), 32'h20);
    bus(1'b1, ra(0, 0, 2, 2), 32'h4);
    bus(1'b1, ra(0, 0, 0, 2), 32'h23);
    req(0, 2'h2, 2'h0, 1'b1, 8'h02, 1'b0); `CHK(op_addr[0], 24'h120023)
    bus(1'b0, ra(0, 0, 0, 2), 32'h0);      `CHK(q, 32'h21)
    req(0, 2'h2, 2'h0, 1'b1, 8'hFC, 1'b1); `CHK(op_addr[0], 24'h120021)
    $display("test circular done");
    // Linear update stays inside the page
    bus(1'b1, ra(1, 0, 0, 3), 32'hFFFF);
    req(1, 2'h3, 2'h0, 1'b1, 8'h01, 1'b0); `CHK(op_addr[1], 24'h34FFFF)
    req(1, 2'h3, 2'h0, 1'b1, 8'h00, 1'b1); `CHK(op_addr[1], 24'h340000)
    $display("test page_limit done");
    // Secondary bank and back
    bus(1'b1, ra(0, 1, 0, 0), 32'h500);
    bus(1'b1, 32'h108, 32'h1);
    req(0, 2'h0, 2'h0, 1'b1, 8'h00, 1'b0); `CHK(op_addr[0], 24'h120500)
    bus(1'b1, 32'h108, 32'h0);
    req(0, 2'h0, 2'h0, 1'b1, 8'h00, 1'b0); `CHK(op_addr[0], 24'h120013)
    $display("test bank done");
    // Both generators in one cycle
    @(posedge clk_sys);
    core_req[0] <= '{valid:1'b1, ptr_sel:2'h0, mod_sel:2'h0, use_imm:1'b1, imm:8'h01, pre:1'b0};
    core_req[1] <= '{valid:1'b1, ptr_sel:2'h1, mod_sel:2'h0, use_imm:1'b1, imm:8'h01, pre:1'b0};
    @(posedge clk_sys);
    core_req[0].valid <= 1'b0;
    core_req[1].valid <= 1'b0;
    #1;
    `CHK(op_addr, {24'h340100, 24'h120013})
    @(posedge clk_sys); #1;
    `CHK(dual_cnt, 8'h01)
    `CHK(last_dm, 24'h340100)
    bus(1'b0, 32'h10C, 32'h0); `CHK(q, 32'h00120013)
    bus(1'b0, 32'h400, 32'h0); `CHK(q, 32'h0)
    `CHK(hresp, 1'b0)
    $display("test dual done");
    conclude();
  end
endmodule // dual_data_address_generator_tb
